// [rtl/irx_link.sv]
// Device end of the inter-repeater expansion link
`default_nettype none

// Contract
// - Carrier low while repeating or propagating collision
// - Send data only while grant is low
// - No data toward link during collision
// - Collision still signalled on all local ports
// - Drive 10 MHz clock when carrier and grant
// - Clock pin is input when granted, not carrier
// - Clock pin high impedance without grant
// - NRZ data synchronous to the data clock
// - Data line released in collision or idle
// - Local transmit collision holds data high
// - Jam low for packet, high for collision
// - Jam high: data 0 multiport, 1 single
// - Jam line released in collision or idle
// - Reset returns all logic except the input synchronisers and buffer data to initial state
module irx_link (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    input wire logic rst_n,
    // Repeater core side
    input wire logic tx_req,
    input wire logic tx_valid,
    input wire logic tx_dat,
    output logic tx_ready,
    input wire logic local_col,
    input wire logic multi_col,
    output logic ports_jam,
    output logic rx_valid,
    output logic rx_dat,
    output logic rx_jam,
    input wire logic rx_ready,
    // Integrator inputs
    input wire logic bus_grant_n,
    input wire logic expansion_collision_n,
    input wire logic grant_present,
    // Link pins
    output logic expansion_carrier_n,
    input wire logic clk_i,
    output logic clk_o,
    output logic clk_oe,
    input wire logic dat_i,
    output logic dat_o,
    output logic dat_oe,
    input wire logic jam_i,
    output logic jam_o,
    output logic jam_oe
);
    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [2:0] s_grant;
    logic [2:0] s_col;
    logic [2:0] s_clk;
    logic [2:0] s_dat;
    logic [2:0] s_jam;
    logic [2:0] s_rst;
    logic grant_st;
    logic col_st;
    logic lclk_st;
    logic rst_st;
    logic lclk_prev;
    logic any_rst;

    always_ff @(posedge clk) begin
        s_grant <= {s_grant[1:0], bus_grant_n};
        s_col <= {s_col[1:0], expansion_collision_n};
        s_clk <= {s_clk[1:0], clk_i};
        s_dat <= {s_dat[1:0], dat_i};
        s_jam <= {s_jam[1:0], jam_i};
        s_rst <= {s_rst[1:0], rst_n};
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge clk) begin
        if (s_grant[1] == s_grant[2]) grant_st <= s_grant[2];
        if (s_col[1] == s_col[2]) col_st <= s_col[2];
        if (s_clk[1] == s_clk[2]) lclk_st <= s_clk[2];
        if (s_rst[1] == s_rst[2]) rst_st <= s_rst[2];
        lclk_prev <= lclk_st;
    end

    assign any_rst = srst || !rst_st;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // Without an integrator the grant pin means nothing and is ignored
    wire granted = !grant_st && grant_present;
    wire xcol = !col_st;
    wire lclk_rise = lclk_st && !lclk_prev;

    // ------------------------------------------------------------------
    // Clock divider for the 10 MHz link clock
    // ------------------------------------------------------------------
    logic [irx_pkg::DIV_W-1:0] div;
    logic div_tick;
    logic clk_q;
    wire div_end = (div == irx_pkg::DIV_LAST);

    // Restarts at every grant: the first bit leaves at once and the first
    // rising edge follows half a period later, so no stale bit is clocked
    always_ff @(posedge clk) begin
        if (any_rst || !clk_oe) begin
            div <= irx_pkg::DIV_RESET;
            clk_q <= 1'b0;
            div_tick <= 1'b0;
        end else begin
            div <= div_end ? irx_pkg::DIV_RESET : div + 5'h01;
            if (div_end) clk_q <= !clk_q;
            // Data changes on the falling edge, peers sample on rising
            div_tick <= div_end && clk_q;
        end
    end

    // ------------------------------------------------------------------
    // Two-entry transmit buffer
    // ------------------------------------------------------------------
    logic [1:0] buf_mem;
    logic buf_wp;
    logic buf_rp;
    logic [1:0] buf_cnt;
    logic bit_take;
    wire buf_full = (buf_cnt == irx_pkg::BUF_DEPTH);
    wire buf_empty = (buf_cnt == 2'h0);
    wire buf_push = tx_valid && tx_ready;
    wire buf_pop = bit_take && !buf_empty;

    always_ff @(posedge clk) begin
        if (any_rst) begin
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            buf_cnt <= 2'h0;
            tx_ready <= 1'b0;
        end else begin
            if (buf_push) buf_mem[buf_wp] <= tx_dat;
            if (buf_push) buf_wp <= !buf_wp;
            if (buf_pop) buf_rp <= !buf_rp;
            buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
            // Registered ready: high exactly when a slot is free
            tx_ready <= (buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop})
                        < irx_pkg::BUF_DEPTH;
        end
    end

    // ------------------------------------------------------------------
    // Link state machine
    // ------------------------------------------------------------------
    irx_pkg::irx_state_e state;
    irx_pkg::irx_state_e next_state;
    wire active = tx_req || local_col || multi_col;

    always_comb begin
        next_state = state;
        case (state)
            irx_pkg::IRX_IDLE: begin
                if (active) next_state = irx_pkg::IRX_SEND;
            end
            irx_pkg::IRX_SEND: begin
                if (!active) next_state = irx_pkg::IRX_IDLE;
                else if (xcol) next_state = irx_pkg::IRX_XCOL;
                else if (local_col || multi_col)
                    next_state = irx_pkg::IRX_JAM;
            end
            irx_pkg::IRX_JAM: begin
                if (!active) next_state = irx_pkg::IRX_IDLE;
                else if (xcol) next_state = irx_pkg::IRX_XCOL;
            end
            irx_pkg::IRX_XCOL: begin
                if (!active && !xcol) next_state = irx_pkg::IRX_IDLE;
            end
            default: next_state = irx_pkg::IRX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (any_rst) state <= irx_pkg::IRX_IDLE;
        else state <= next_state;
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    wire carrier = (state != irx_pkg::IRX_IDLE);
    wire sending = (state == irx_pkg::IRX_SEND) && granted && !xcol;
    wire jamming = (state == irx_pkg::IRX_JAM) && granted && !xcol;
    assign bit_take = sending && (div_tick || !clk_oe);
    wire next_dat_oe = sending || jamming;
    // Local collision holds one; multiport collision holds zero
    wire jam_level = local_col && !multi_col;
    wire next_dat = jamming ? jam_level
                  : (buf_pop ? buf_mem[buf_rp] : dat_o);
    wire next_clk_oe = carrier && granted && grant_present;

    always_ff @(posedge clk) begin
        if (any_rst) begin
            expansion_carrier_n <= 1'b1;
            clk_o <= 1'b0;
            clk_oe <= 1'b0;
            dat_o <= 1'b0;
            dat_oe <= 1'b0;
            jam_o <= 1'b0;
            jam_oe <= 1'b0;
            ports_jam <= 1'b0;
        end else begin
            expansion_carrier_n <= !carrier;
            clk_o <= clk_q;
            clk_oe <= next_clk_oe;
            dat_o <= next_dat;
            dat_oe <= next_dat_oe;
            jam_o <= jamming;
            jam_oe <= next_dat_oe;
            ports_jam <= xcol || local_col || multi_col;
        end
    end

    // ------------------------------------------------------------------
    // Receive path: sample on the peer clock's rising edge
    // ------------------------------------------------------------------
    wire rx_take = lclk_rise && !carrier && granted && grant_present
                   && !xcol;
    // Output stage plus one spare word; the link cannot wait, so a stall
    // longer than two bit periods still overflows
    irx_pkg::irx_rx_s rx_word;
    irx_pkg::irx_rx_s rx_skid;
    logic rx_skid_valid;
    wire rx_out_free = !rx_valid || rx_ready;
    assign rx_word = {s_jam[2], s_dat[2]};

    always_ff @(posedge clk) begin
        if (any_rst) begin
            rx_valid <= 1'b0;
            rx_dat <= 1'b0;
            rx_jam <= 1'b0;
            rx_skid <= 2'h0;
            rx_skid_valid <= 1'b0;
        end else if (rx_out_free) begin
            rx_valid <= rx_skid_valid || rx_take;
            if (rx_skid_valid) begin
                {rx_jam, rx_dat} <= rx_skid;
            end else if (rx_take) begin
                {rx_jam, rx_dat} <= rx_word;
            end
            if (rx_skid_valid) rx_skid <= rx_word;
            rx_skid_valid <= rx_skid_valid && rx_take;
        end else if (rx_take && !rx_skid_valid) begin
            rx_skid <= rx_word;
            rx_skid_valid <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_carrier_tracks: assert property (
        @(posedge clk) disable iff (any_rst)
        carrier |=> !expansion_carrier_n)
        else $error("carrier output not low while active");

    a_data_needs_grant: assert property (
        @(posedge clk) disable iff (any_rst)
        $rose(dat_oe) |-> $past(granted))
        else $error("data driven without grant");

    a_no_data_xcol: assert property (
        @(posedge clk) disable iff (any_rst)
        xcol |=> !dat_oe)
        else $error("data driven during expansion collision");

    a_ports_jam_xcol: assert property (
        @(posedge clk) disable iff (any_rst)
        xcol |=> ports_jam)
        else $error("local ports not jammed on collision");

    a_clock_release: assert property (
        @(posedge clk) disable iff (any_rst)
        !grant_present |=> !clk_oe)
        else $error("clock pin driven without grant line");

    a_idle_release: assert property (
        @(posedge clk) disable iff (any_rst)
        (state == irx_pkg::IRX_IDLE) |=> !dat_oe && !jam_oe)
        else $error("link pins driven while idle");

    a_local_col_high: assert property (
        @(posedge clk) disable iff (any_rst)
        jamming && local_col && !multi_col |=> dat_o && jam_o)
        else $error("local collision not held high");

    a_jam_packet_low: assert property (
        @(posedge clk) disable iff (any_rst)
        sending |=> dat_oe && !jam_o)
        else $error("jam not low during packet");

    a_clock_drive: assert property (
        @(posedge clk) disable iff (any_rst)
        carrier && granted |=> clk_oe)
        else $error("link clock not driven while granted");

    a_rx_hold: assert property (
        @(posedge clk) disable iff (any_rst)
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_dat))
        else $error("received bit dropped before taken");

    a_no_jam_xcol: assert property (
        @(posedge clk) disable iff (any_rst)
        xcol |=> !jam_oe)
        else $error("jam driven during expansion collision");
endmodule
`default_nettype wire

// [shared/irx_pkg.sv]
// Package for the expansion link: constants, states and carrier structs
`default_nettype none
package irx_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int LINK_CLK_MHZ = 10;
    // Half period of the 10 MHz link clock in system cycles
    localparam int HALF_CYCLES = CLK_MHZ / (2 * LINK_CLK_MHZ);
    localparam int DIV_W = 5;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYCLES - 1);
    localparam logic [DIV_W-1:0] DIV_RESET = 5'h00;
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    // ------------------------------------------------------------------
    // Link states, Gray coded along idle, send, jam, expansion collision
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IRX_IDLE = 2'b00,
        IRX_SEND = 2'b01,
        IRX_JAM = 2'b11,
        IRX_XCOL = 2'b10
    } irx_state_e;

    // Output and enable signals of a two-way pin
    typedef struct packed {
        logic o;
        logic oe;
    } irx_pin_s;

    // Word received from the link: data bit and jam flag
    typedef struct packed {
        logic jam;
        logic dat;
    } irx_rx_s;
endpackage
`default_nettype wire

// [tb/irx_partner.sv]
// Integrator and one peer repeater facing the device end of the link
`default_nettype none
module irx_partner #(
    parameter logic [7:0] PAT = 8'hb4
) (
    // System clock and peer frame request
    input wire logic clk,
    input wire logic peer_req,
    // Device pins
    input wire logic expansion_carrier_n,
    input wire logic clk_o,
    input wire logic clk_oe,
    input wire logic dat_o,
    input wire logic dat_oe,
    input wire logic jam_o,
    input wire logic jam_oe,
    // Integrator lines and resolved wires
    output logic bus_grant_n,
    output logic expansion_collision_n,
    output logic clk_i,
    output logic dat_i,
    output logic jam_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lk = 1'b0;
    logic [2:0] idx = 3'h0;
    logic last_d = 1'b0;
    logic last_j = 1'b0;
    logic dev_on;
    logic peer_tx;
    assign dev_on = !expansion_carrier_n;
    assign bus_grant_n = !(dev_on ^ peer_req);
    assign expansion_collision_n = !(dev_on && peer_req);
    // Peer sends only while granted and keeps off the line in a collision
    assign peer_tx = peer_req && expansion_collision_n;
    // Peer clock stands still between frames; offset keeps it off clk phase
    initial begin
        #7;
        forever #40 begin
            if (!peer_req) idx = 3'h0;
            else if (lk) idx = idx + 3'h1;
            lk = peer_req && !lk;
        end
    end
    assign clk_i = clk_oe ? clk_o : (lk && peer_tx);
    // Released lines show no stale level: they flip every cycle
    assign dat_i = dat_oe ? dat_o : (peer_tx ? PAT[idx] : !last_d);
    assign jam_i = jam_oe ? jam_o : (peer_tx ? 1'b0 : !last_j);
    always @(posedge clk) begin
        last_d <= dat_i;
        last_j <= jam_i;
    end
endmodule
`default_nettype wire

// [tb/irx_link_tb.sv]
// Self-checking bench for the device end of the expansion link
`default_nettype none
module irx_link_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, srst = 1'b1, rst_n = 1'b1, tx_req = 1'b0;
    logic tx_valid = 1'b0, tx_dat = 1'b0, local_col = 1'b0;
    logic multi_col = 1'b0, rx_ready = 1'b0, grant_present = 1'b1;
    logic peer_req = 1'b0;
    logic tx_ready, ports_jam, rx_valid, rx_dat, rx_jam;
    logic expansion_carrier_n, clk_o, clk_oe, dat_o, dat_oe, jam_o, jam_oe;
    logic bus_grant_n, expansion_collision_n, clk_i, dat_i, jam_i;
    int err_count = 0;
    int n_tests = 0;
    int i;
    logic [3:0] got;
    logic [7:0] per;
    irx_link u_irx_link (.clk, .srst, .rst_n, .tx_req, .tx_valid, .tx_dat,
        .tx_ready, .local_col, .multi_col, .ports_jam, .rx_valid, .rx_dat,
        .rx_jam, .rx_ready, .bus_grant_n, .expansion_collision_n,
        .grant_present, .expansion_carrier_n, .clk_i, .clk_o, .clk_oe,
        .dat_i, .dat_o, .dat_oe, .jam_i, .jam_o, .jam_oe);
    irx_partner u_irx_partner (.clk, .peer_req, .expansion_carrier_n,
        .clk_o, .clk_oe, .dat_o, .dat_oe, .jam_o, .jam_oe, .bus_grant_n,
        .expansion_collision_n, .clk_i, .dat_i, .jam_i);
    initial forever #2 clk = !clk;
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Bounded waits end the run when their limit is used up
    task automatic tmo(input int n);
        if (n >= 2000) begin
            chk(8'h00, 8'h01);
            stop_test();
        end
    endtask
    task automatic push2(input logic [1:0] b);
        int j;
        tx_valid <= 1'b1;
        for (int n = 0; n < 2; n++) begin
            tx_dat <= b[n];
            j = 0;
            do begin
                @(posedge clk);
                j++;
            end while (tx_ready !== 1'b1 && j < 2000);
            tmo(j);
        end
        tx_valid <= 1'b0;
    endtask
    // Serial bits at each rise of the driven link clock, and its period
    task automatic capture;
        int k;
        int p0;
        logic lo;
        k = 0;
        p0 = 0;
        lo = 1'b0;
        for (int n = 0; n < 4 && k < 2000; k++) begin
            @(posedge clk);
            if (clk_oe === 1'b1 && clk_o === 1'b1 && lo === 1'b0) begin
                got = {dat_o, got[3:1]};
                per = 8'(k - p0);
                p0 = k;
                n++;
            end
            lo = clk_o;
        end
        tmo(k);
    endtask
    task automatic wait_carrier(input logic v);
        for (i = 0; i < 2000 && expansion_carrier_n !== v; i++) @(posedge clk);
        tmo(i);
    endtask
    task automatic t_send;
        push2(2'b01);
        repeat (2) @(posedge clk);
        chk(tx_ready, 0);
        tx_req <= 1'b1;
        fork
            push2(2'b11);
            capture();
        join
        chk(got, 4'hd);
        chk(per, 24);
        chk({expansion_carrier_n, jam_oe, jam_o}, 3'b010);
        local_col <= 1'b1;
        for (i = 0; i < 2000 && jam_o !== 1'b1; i++) @(posedge clk);
        tmo(i);
        repeat (2) @(posedge clk);
        chk({dat_oe, dat_o, ports_jam}, 3'b111);
        multi_col <= 1'b1;
        for (i = 0; i < 2000 && dat_o !== 1'b0; i++) @(posedge clk);
        tmo(i);
        chk({dat_oe, jam_oe, jam_o}, 3'b111);
        tx_req <= 1'b0;
        local_col <= 1'b0;
        multi_col <= 1'b0;
        wait_carrier(1'b1);
        repeat (2) @(posedge clk);
        chk({clk_oe, dat_oe, jam_oe}, 0);
        $display("test send done");
    endtask
    task automatic t_xcol;
        tx_req <= 1'b1;
        for (i = 0; i < 2000 && dat_oe !== 1'b1; i++) @(posedge clk);
        tmo(i);
        peer_req <= 1'b1;
        for (i = 0; i < 2000 && dat_oe !== 1'b0; i++) @(posedge clk);
        tmo(i);
        repeat (2) @(posedge clk);
        chk({dat_oe, jam_oe, ports_jam}, 3'b001);
        chk(expansion_carrier_n, 0);
        tx_req <= 1'b0;
        peer_req <= 1'b0;
        wait_carrier(1'b1);
        $display("test collision done");
    endtask
    task automatic t_recv;
        peer_req <= 1'b1;
        for (i = 0; i < 2000 && rx_valid !== 1'b1; i++) @(posedge clk);
        tmo(i);
        repeat (30) @(posedge clk);
        chk({clk_oe, rx_jam}, 0);
        rx_ready <= 1'b1;
        for (int n = 0; n < 4 && i < 4000; i++) begin
            @(posedge clk);
            if (rx_valid === 1'b1) begin
                got = {rx_dat, got[3:1]};
                n++;
            end
        end
        tmo(i - 2000);
        chk(got, 4'h4);
        peer_req <= 1'b0;
        $display("test receive done");
    endtask
    task automatic t_nogrant;
        grant_present <= 1'b0;
        tx_req <= 1'b1;
        repeat (60) @(posedge clk);
        chk({clk_oe, dat_oe}, 0);
        grant_present <= 1'b1;
        for (i = 0; i < 2000 && dat_oe !== 1'b1; i++) @(posedge clk);
        tmo(i);
        chk(clk_oe, 1);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        chk({expansion_carrier_n, clk_oe, dat_oe, jam_oe}, 4'h8);
        tx_req <= 1'b0;
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        $display("test no grant and pin reset done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        chk({expansion_carrier_n, clk_oe, dat_oe, jam_oe}, 4'h8);
        srst <= 1'b0;
        $display("test reset done");
        t_send();
        t_xcol();
        t_recv();
        t_nogrant();
        stop_test();
    end
endmodule
`default_nettype wire
